// ---- hw/hrfp_pkg.sv ----
// Shared constants and pin bundles for the host register and FIFO port.
package hrfp_pkg;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          FIFO_AW       = 5;
    localparam int          FIFO_CW       = 6;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 16;
    localparam int          REG_AW        = 6;
    localparam int          STROBE_MAX_MHZ = 33;
    localparam logic [5:0]  REG_TX_STATUS = 6'h00;
    localparam logic [5:0]  REG_RX_STATUS = 6'h01;
    localparam logic [5:0]  REG_THRESHOLD = 6'h02;
    localparam logic [5:0]  REG_CONFIG    = 6'h03;
    localparam logic [15:0] REG_RESET_VAL = 16'h0000;
    localparam int          TX_TH_LSB     = 0;
    localparam int          RX_TH_LSB     = 8;
    localparam int          TH_W          = 6;

    typedef struct packed {
        logic        sel_n;
        logic        rd_n;
        logic        wr_n;
        logic [5:0]  addr;
        logic [1:0]  be_n;
        logic        width;
        logic [15:0] data;
    } hrfp_reg_pins_t;

    typedef struct packed {
        logic        tx_sel_n;
        logic        tx_wr_n;
        logic        rx_sel_n;
        logic        rx_rd_n;
        logic        strobe;
        logic        order;
        logic        eof;
        logic [31:0] data;
    } hrfp_fifo_pins_t;
endpackage

// ---- hw/hrfp_port.sv ----
// Host register port and FIFO strobe port of the data link controller.
// Contract
// - Width select high: 16-bit, low: 8-bit.
// - Active-low byte lanes pick bytes in 16-bit.
// - Drive register bus only during read with select.
// - Interrupt high until status register read.
// - Reset zeroes registers, FIFOs and counters.
// - Byte order select high sends MSB first.
// - Receive select enables receive status outputs.
// - Transmit select enables transmit status outputs.
// - Receive read needs read enable and select.
// - Transmit write needs write enable and select.
// - Strobe clock rising edges write or read FIFOs.
// - Register write captured at strobe rising edge.
// - Transmit ready when free space meets threshold.
// - Receive ready on threshold or stored status word.
// - End-of-frame marker is the 33rd FIFO bit.
`timescale 1ns/1ps
module hrfp_port #(
    parameter int DEPTH = hrfp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // Register port pins
    input  wire logic        reg_port_select_n_i,
    input  wire logic        reg_read_n_i,
    input  wire logic        reg_write_n_i,
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [1:0]  reg_byte_lane_enable_n_i,
    input  wire logic        reg_width_select_i,
    input  wire logic [15:0] reg_data_bus_i,
    output logic      [15:0] reg_data_bus_o,
    output logic             reg_data_bus_oe_o,
    output logic             interrupt_o,
    // FIFO port pins
    input  wire logic        tx_port_select_n_i,
    input  wire logic        tx_fifo_write_enable_n_i,
    input  wire logic        rx_port_select_n_i,
    input  wire logic        rx_fifo_read_enable_n_i,
    input  wire logic        fifo_strobe_clock_i,
    input  wire logic        fifo_byte_order_select_i,
    input  wire logic        frame_end_marker_i,
    input  wire logic [31:0] fifo_data_bus_i,
    output logic      [31:0] fifo_data_bus_o,
    output logic             fifo_data_bus_oe_o,
    output logic             frame_end_marker_o,
    output logic             frame_end_marker_oe_o,
    output logic             tx_space_ready_o,
    output logic             tx_space_ready_oe_o,
    output logic             rx_data_ready_o,
    output logic             rx_data_ready_oe_o,
    output logic             tx_retry_flag_o,
    output logic             tx_retry_flag_oe_o,
    output logic             rx_side_status_out_o,
    output logic             rx_side_status_out_oe_o,
    // MAC engine side
    input  wire logic        tx_event_i,
    input  wire logic        rx_event_i,
    input  wire logic        tx_retry_i,
    input  wire logic        rx_side_status_i,
    input  wire logic        tx_pop_i,
    output logic      [31:0] tx_word_o,
    output logic             tx_word_eof_o,
    output logic             tx_word_valid_o,
    input  wire logic        rx_push_i,
    input  wire logic [31:0] rx_word_i,
    input  wire logic        rx_word_eof_i
);
    // Reset release passes two flops so no pointer sees a runt release.
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Pins come from the host's timing, so each passes three flops.
    hrfp_pkg::hrfp_reg_pins_t  rp0, rp1, rp2, rp_lvl, rp_in, next_rp_lvl;
    hrfp_pkg::hrfp_fifo_pins_t fp0, fp1, fp2, fp_lvl, fp_in, next_fp_lvl;
    assign rp_in = '{reg_port_select_n_i, reg_read_n_i, reg_write_n_i,
                     reg_addr_i, reg_byte_lane_enable_n_i,
                     reg_width_select_i, reg_data_bus_i};
    assign fp_in = '{tx_port_select_n_i, tx_fifo_write_enable_n_i,
                     rx_port_select_n_i, rx_fifo_read_enable_n_i,
                     fifo_strobe_clock_i, fifo_byte_order_select_i,
                     frame_end_marker_i, fifo_data_bus_i};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rp0 <= '1;
            rp1 <= '1;
            rp2 <= '1;
            fp0 <= '1;
            fp1 <= '1;
            fp2 <= '1;
        end else begin
            rp0 <= rp_in;
            rp1 <= rp0;
            rp2 <= rp1;
            fp0 <= fp_in;
            fp1 <= fp0;
            fp2 <= fp1;
        end
    end
    // Each bit counts once its second and third stages agree; filtering
    // bit by bit keeps a busy data bus from stalling the strobe.
    wire [$bits(rp_in)-1:0] rp_ok = ~(rp1 ^ rp2);
    wire [$bits(fp_in)-1:0] fp_ok = ~(fp1 ^ fp2);
    assign next_rp_lvl = (rp2 & rp_ok) | (rp_lvl & ~rp_ok);
    assign next_fp_lvl = (fp2 & fp_ok) | (fp_lvl & ~fp_ok);
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rp_lvl <= '1;
            fp_lvl <= '1;
        end else begin
            rp_lvl <= next_rp_lvl;
            fp_lvl <= next_fp_lvl;
        end
    end
    wire reg_sel   = !rp_lvl.sel_n;
    wire reg_rd    = reg_sel && !rp_lvl.rd_n;
    wire wr_rise   = rp1.wr_n && rp2.wr_n && !rp_lvl.wr_n && reg_sel;
    wire rd_rise   = rp1.rd_n && rp2.rd_n && !rp_lvl.rd_n && reg_sel;
    wire stb_rise  = fp1.strobe && fp2.strobe && !fp_lvl.strobe;
    wire tx_en     = !fp_lvl.tx_sel_n;
    wire rx_en     = !fp_lvl.rx_sel_n;
    wire tx_wr_en  = tx_en && !fp_lvl.tx_wr_n;
    wire rx_rd_en  = rx_en && !fp_lvl.rx_rd_n;

    // Register file.
    logic [15:0] tx_status, rx_status, threshold, config_reg;
    wire  [1:0]  lane_we = rp_lvl.width ? ~rp_lvl.be_n : 2'h1;
    wire  [15:0] lane_mask = {{8{lane_we[1]}}, {8{lane_we[0]}}};
    wire         hit_thr = (rp_lvl.addr == hrfp_pkg::REG_THRESHOLD);
    wire         hit_cfg = (rp_lvl.addr == hrfp_pkg::REG_CONFIG);
    wire         rd_txs  = rd_rise && rp_lvl.addr == hrfp_pkg::REG_TX_STATUS;
    wire         rd_rxs  = rd_rise && rp_lvl.addr == hrfp_pkg::REG_RX_STATUS;
    wire  [15:0] wdata   = rp_lvl.data & lane_mask;
    logic [15:0] rdata;
    always_comb begin
        unique case (rp_lvl.addr)
            hrfp_pkg::REG_TX_STATUS: rdata = tx_status;
            hrfp_pkg::REG_RX_STATUS: rdata = rx_status;
            hrfp_pkg::REG_THRESHOLD: rdata = threshold;
            hrfp_pkg::REG_CONFIG:    rdata = config_reg;
            default:                 rdata = 16'h0000;
        endcase
    end
    wire [15:0] rdata_lane = rdata & lane_mask;
    // A new event outranks the clear of the read that races it.
    wire [15:0] next_tx_status = rd_txs ? {15'h0000, tx_event_i}
                                        : tx_status | {15'h0000, tx_event_i};
    wire [15:0] next_rx_status = rd_rxs ? {15'h0000, rx_event_i}
                                        : rx_status | {15'h0000, rx_event_i};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_status  <= hrfp_pkg::REG_RESET_VAL;
            rx_status  <= hrfp_pkg::REG_RESET_VAL;
            threshold  <= hrfp_pkg::REG_RESET_VAL;
            config_reg <= hrfp_pkg::REG_RESET_VAL;
        end else begin
            tx_status <= next_tx_status;
            rx_status <= next_rx_status;
            if (wr_rise && hit_thr)
                threshold <= (threshold & ~lane_mask) | wdata;
            if (wr_rise && hit_cfg)
                config_reg <= (config_reg & ~lane_mask) | wdata;
        end
    end

    // FIFOs hold 33 bits; bit 32 is the end-of-frame marker.
    logic [32:0]              tx_mem [DEPTH];
    logic [32:0]              rx_mem [DEPTH];
    logic [hrfp_pkg::FIFO_AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [hrfp_pkg::FIFO_CW-1:0] tx_cnt, rx_cnt, rx_eofs;
    localparam logic [hrfp_pkg::FIFO_CW-1:0] FULL_CNT =
        hrfp_pkg::FIFO_CW'(DEPTH);
    wire tx_push = stb_rise && tx_wr_en && tx_cnt != FULL_CNT;
    wire tx_pop  = tx_pop_i && tx_cnt != '0;
    wire rx_pop  = stb_rise && rx_rd_en && rx_cnt != '0;
    wire rx_push = rx_push_i && rx_cnt != FULL_CNT;
    wire [32:0] rx_head = rx_mem[rx_rp];
    wire [31:0] tx_raw  = tx_mem[tx_rp][31:0];
    // Bits 7:0 leave first, so big endian swaps the word.
    wire [31:0] tx_ord  = fp_lvl.order ? {tx_raw[7:0], tx_raw[15:8],
                          tx_raw[23:16], tx_raw[31:24]} : tx_raw;
    wire [hrfp_pkg::FIFO_CW-1:0] tx_free = FULL_CNT - tx_cnt;
    wire [5:0] tx_th = threshold[hrfp_pkg::TX_TH_LSB +: hrfp_pkg::TH_W];
    wire [5:0] rx_th = threshold[hrfp_pkg::RX_TH_LSB +: hrfp_pkg::TH_W];
    always_ff @(posedge clk_i) begin
        if (tx_push) tx_mem[tx_wp] <= {fp_lvl.eof, fp_lvl.data};
        if (rx_push) rx_mem[rx_wp] <= {rx_word_eof_i, rx_word_i};
    end
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_wp   <= '0;
            tx_rp   <= '0;
            tx_cnt  <= '0;
            rx_wp   <= '0;
            rx_rp   <= '0;
            rx_cnt  <= '0;
            rx_eofs <= '0;
        end else begin
            tx_wp   <= tx_wp + hrfp_pkg::FIFO_AW'(tx_push);
            tx_rp   <= tx_rp + hrfp_pkg::FIFO_AW'(tx_pop);
            tx_cnt  <= tx_cnt + hrfp_pkg::FIFO_CW'(tx_push)
                              - hrfp_pkg::FIFO_CW'(tx_pop);
            rx_wp   <= rx_wp + hrfp_pkg::FIFO_AW'(rx_push);
            rx_rp   <= rx_rp + hrfp_pkg::FIFO_AW'(rx_pop);
            rx_cnt  <= rx_cnt + hrfp_pkg::FIFO_CW'(rx_push)
                              - hrfp_pkg::FIFO_CW'(rx_pop);
            rx_eofs <= rx_eofs + hrfp_pkg::FIFO_CW'(rx_push && rx_word_eof_i)
                               - hrfp_pkg::FIFO_CW'(rx_pop && rx_head[32]);
        end
    end

    // Every pin output is registered; status enables follow the selects, data bus enables the selected reads.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_data_bus_o          <= '0;
            reg_data_bus_oe_o       <= 1'b0;
            interrupt_o             <= 1'b0;
            fifo_data_bus_o         <= '0;
            fifo_data_bus_oe_o      <= 1'b0;
            frame_end_marker_o      <= 1'b0;
            frame_end_marker_oe_o   <= 1'b0;
            tx_space_ready_o        <= 1'b0;
            tx_space_ready_oe_o     <= 1'b0;
            rx_data_ready_o         <= 1'b0;
            rx_data_ready_oe_o      <= 1'b0;
            tx_retry_flag_o         <= 1'b0;
            tx_retry_flag_oe_o      <= 1'b0;
            rx_side_status_out_o    <= 1'b0;
            rx_side_status_out_oe_o <= 1'b0;
            tx_word_o               <= '0;
            tx_word_eof_o           <= 1'b0;
            tx_word_valid_o         <= 1'b0;
        end else begin
            reg_data_bus_o          <= rdata_lane;
            reg_data_bus_oe_o       <= reg_rd;
            interrupt_o             <= |{next_tx_status, next_rx_status};
            if (rx_pop) begin
                fifo_data_bus_o     <= rx_head[31:0];
                frame_end_marker_o  <= rx_head[32];
            end
            fifo_data_bus_oe_o      <= rx_rd_en;
            frame_end_marker_oe_o   <= rx_rd_en;
            tx_space_ready_o        <= tx_free >= tx_th;
            tx_space_ready_oe_o     <= tx_en;
            rx_data_ready_o         <= rx_cnt >= rx_th || |rx_eofs;
            rx_data_ready_oe_o      <= rx_en;
            tx_retry_flag_o         <= tx_retry_i;
            tx_retry_flag_oe_o      <= tx_en;
            rx_side_status_out_o    <= rx_side_status_i;
            rx_side_status_out_oe_o <= rx_en;
            tx_word_o               <= tx_ord;
            tx_word_eof_o           <= tx_mem[tx_rp][32];
            tx_word_valid_o         <= tx_cnt != '0;
        end
    end

    // Checks.
    property p_reg_drive;
        @(posedge clk_i) disable iff (!rst_n)
        reg_data_bus_oe_o |-> $past(reg_rd);
    endproperty
    a_reg_drive: assert property (p_reg_drive)
        else $error("reg bus driven idle");
    property p_irq_hold;
        @(posedge clk_i) disable iff (!rst_n)
        (interrupt_o && !rd_txs && !rd_rxs) |=> interrupt_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped early");
    property p_irq_set;
        @(posedge clk_i) disable iff (!rst_n)
        tx_event_i |=> interrupt_o;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("irq not raised");
    property p_narrow;
        @(posedge clk_i) disable iff (!rst_n)
        !rp_lvl.width |=> reg_data_bus_o[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("upper byte in 8-bit");
    property p_tx_write;
        @(posedge clk_i) disable iff (!rst_n)
        $changed(tx_wp) |-> $past(tx_wr_en);
    endproperty
    a_tx_write: assert property (p_tx_write)
        else $error("write w/o enable");
    property p_rx_read;
        @(posedge clk_i) disable iff (!rst_n)
        rx_pop |=> fifo_data_bus_oe_o
                   && {frame_end_marker_o, fifo_data_bus_o} == $past(rx_head);
    endproperty
    a_rx_read: assert property (p_rx_read)
        else $error("read word wrong");
    property p_tx_oe;
        @(posedge clk_i) disable iff (!rst_n)
        tx_en |=> tx_space_ready_oe_o && tx_retry_flag_oe_o;
    endproperty
    a_tx_oe: assert property (p_tx_oe)
        else $error("tx drivers off");
    property p_rx_oe;
        @(posedge clk_i) disable iff (!rst_n)
        !rx_en |=> !rx_data_ready_oe_o && !rx_side_status_out_oe_o;
    endproperty
    a_rx_oe: assert property (p_rx_oe)
        else $error("rx drivers on");
    property p_rx_ready;
        @(posedge clk_i) disable iff (!rst_n)
        (rx_eofs != '0) |=> rx_data_ready_o;
    endproperty
    a_rx_ready: assert property (p_rx_ready)
        else $error("rx ready missing");
    property p_tx_ready;
        @(posedge clk_i) disable iff (!rst_n)
        (tx_free < tx_th) |=> !tx_space_ready_o;
    endproperty
    a_tx_ready: assert property (p_tx_ready)
        else $error("tx ready wrong");
    c_tx_fill: cover property (@(posedge clk_i) tx_cnt == FULL_CNT);
    c_rx_eof: cover property (@(posedge clk_i) rx_pop && rx_head[32]);
    c_irq_clr: cover property (@(posedge clk_i) interrupt_o ##1 !interrupt_o);
    c_reg_wr: cover property (@(posedge clk_i) wr_rise && hit_thr);
endmodule

// ---- tb/hrfp_host_model.sv ----
// Host-side model: register strobes and the free-running FIFO strobe.
`timescale 1ns/1ps
module hrfp_host_model (
    // Clock
    input  wire logic                 clk_i,
    // Levels seen by the host
    input  wire logic [15:0]          reg_bus_i,
    input  wire logic                 reg_oe_i,
    input  wire logic [32:0]          fifo_bus_i,
    // Host pins
    output hrfp_pkg::hrfp_reg_pins_t  reg_pins_o,
    output hrfp_pkg::hrfp_fifo_pins_t fifo_pins_o
);
    logic [2:0]  phase = 3'h0;
    logic [32:0] rd_word;

    initial begin
        reg_pins_o = '1;
        fifo_pins_o = '1;
        fifo_pins_o.order = 1'h0;
    end

    // Four cycles a half period keeps the strobe far below its ceiling.
    always @(posedge clk_i) begin
        phase <= phase + 3'h1;
        fifo_pins_o.strobe <= (phase + 3'h1) > 3'h3;
    end

    // Selects move only while the strobe is low, so a call spans one rise.
    task automatic cyc(input logic tx_n, input logic wr_n, input logic rx_n,
                       input logic rd_n, input logic [32:0] w);
        while (phase != 3'h7) @(posedge clk_i);
        fifo_pins_o.tx_sel_n <= tx_n;
        fifo_pins_o.tx_wr_n <= wr_n;
        fifo_pins_o.rx_sel_n <= rx_n;
        fifo_pins_o.rx_rd_n <= rd_n;
        {fifo_pins_o.eof, fifo_pins_o.data} <= w;
        repeat (4) @(posedge clk_i);
        rd_word = fifo_bus_i;
        repeat (4) @(posedge clk_i);
    endtask

    // Each strobe level is held eight cycles, well past the pin filter.
    task automatic access(input logic wr, input logic [5:0] a,
                          input logic [1:0] be, input logic w,
                          input logic [15:0] d, output logic [15:0] q,
                          output logic oe);
        @(posedge clk_i);
        reg_pins_o.sel_n <= 1'h0;
        reg_pins_o.addr <= a;
        reg_pins_o.be_n <= be;
        reg_pins_o.width <= w;
        reg_pins_o.data <= d;
        reg_pins_o.wr_n <= ~wr;
        reg_pins_o.rd_n <= wr;
        repeat (8) @(posedge clk_i);
        q = reg_bus_i;
        oe = reg_oe_i;
        reg_pins_o.wr_n <= 1'h1;
        reg_pins_o.rd_n <= 1'h1;
        repeat (8) @(posedge clk_i);
        reg_pins_o.sel_n <= 1'h1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking testbench for the host register and FIFO port.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic wr; logic [5:0] a; logic [1:0] be; logic w; logic [15:0] d;
    } hrfp_row_t;
    localparam int LIMIT = 20000;
    logic clk_i, arst_n_i, tx_event_i, rx_event_i, tx_retry_i, tx_pop_i;
    logic rx_side_status_i, rx_push_i, rx_word_eof_i, reg_data_bus_oe_o;
    logic interrupt_o, fifo_data_bus_oe_o, frame_end_marker_o, tx_word_eof_o;
    logic frame_end_marker_oe_o, tx_space_ready_o, tx_space_ready_oe_o;
    logic rx_data_ready_o, rx_data_ready_oe_o, tx_retry_flag_o;
    logic tx_word_valid_o;
    logic tx_retry_flag_oe_o, rx_side_status_out_o, rx_side_status_out_oe_o;
    logic [15:0] reg_data_bus_o, reg_bus, q;
    logic [31:0] rx_word_i, fifo_data_bus_o, tx_word_o;
    logic [32:0] fifo_bus;
    hrfp_pkg::hrfp_reg_pins_t  rp;
    hrfp_pkg::hrfp_fifo_pins_t fp;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    hrfp_row_t rows [13] = '{
        '{1'h0, 6'h00, 2'h0, 1'h1, 16'h0000},
        '{1'h0, 6'h03, 2'h0, 1'h1, 16'h0000},
        '{1'h1, 6'h03, 2'h0, 1'h1, 16'ha55a},
        '{1'h1, 6'h03, 2'h2, 1'h1, 16'h1234},
        '{1'h0, 6'h03, 2'h0, 1'h1, 16'ha534},
        '{1'h0, 6'h03, 2'h1, 1'h1, 16'ha500},
        '{1'h1, 6'h03, 2'h3, 1'h0, 16'hff3c},
        '{1'h0, 6'h03, 2'h0, 1'h1, 16'ha53c},
        '{1'h0, 6'h03, 2'h3, 1'h0, 16'h003c},
        '{1'h1, 6'h3f, 2'h0, 1'h1, 16'hbeef},
        '{1'h0, 6'h3f, 2'h0, 1'h1, 16'h0000},
        '{1'h1, 6'h01, 2'h0, 1'h1, 16'hffff},
        '{1'h0, 6'h01, 2'h0, 1'h1, 16'h0000}};

    // Undriven lines show the inverse of the host's last value: register lines while rd_n is low, FIFO lines while tx_wr_n is high.
    assign reg_bus = reg_data_bus_oe_o ? reg_data_bus_o :
                     rp.rd_n ? rp.data : ~rp.data;
    assign fifo_bus = fifo_data_bus_oe_o ?
                      {frame_end_marker_o, fifo_data_bus_o} :
                      fp.tx_wr_n ? ~{fp.eof, fp.data} : {fp.eof, fp.data};

    hrfp_host_model host (.clk_i, .reg_bus_i(reg_bus),
        .reg_oe_i(reg_data_bus_oe_o), .fifo_bus_i(fifo_bus),
        .reg_pins_o(rp), .fifo_pins_o(fp));

    hrfp_port dut (.clk_i, .arst_n_i,
        .reg_port_select_n_i(rp.sel_n), .reg_read_n_i(rp.rd_n),
        .reg_write_n_i(rp.wr_n), .reg_addr_i(rp.addr),
        .reg_byte_lane_enable_n_i(rp.be_n), .reg_width_select_i(rp.width),
        .reg_data_bus_i(reg_bus), .reg_data_bus_o, .reg_data_bus_oe_o,
        .interrupt_o, .tx_port_select_n_i(fp.tx_sel_n),
        .tx_fifo_write_enable_n_i(fp.tx_wr_n), .rx_port_select_n_i(fp.rx_sel_n),
        .rx_fifo_read_enable_n_i(fp.rx_rd_n), .fifo_strobe_clock_i(fp.strobe),
        .fifo_byte_order_select_i(fp.order), .frame_end_marker_i(fifo_bus[32]),
        .fifo_data_bus_i(fifo_bus[31:0]), .fifo_data_bus_o, .fifo_data_bus_oe_o,
        .frame_end_marker_o, .frame_end_marker_oe_o, .tx_space_ready_o,
        .tx_space_ready_oe_o, .rx_data_ready_o, .rx_data_ready_oe_o,
        .tx_retry_flag_o, .tx_retry_flag_oe_o, .rx_side_status_out_o,
        .rx_side_status_out_oe_o, .tx_event_i, .rx_event_i, .tx_retry_i,
        .rx_side_status_i, .tx_pop_i, .tx_word_o, .tx_word_eof_o,
        .tx_word_valid_o, .rx_push_i, .rx_word_i, .rx_word_eof_i);

    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string m, input logic [32:0] g, e);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t ns: %s", $time, m);
        end
    endtask
    task automatic chk_b(input string m, input logic g, e);
        chk(m, {32'h0, g}, {32'h0, e});
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rop(input hrfp_row_t x);
        logic oe;
        host.access(x.wr, x.a, x.be, x.w, x.d, q, oe);
        chk_b("bus drive", oe, ~x.wr);
        chk_b("bus released", reg_data_bus_oe_o, 1'h0);
    endtask
    task automatic mac(input logic tx, input logic [32:0] w);
        @(posedge clk_i);
        {tx_pop_i, rx_push_i} <= {tx, ~tx};
        {rx_word_eof_i, rx_word_i} <= w;
        @(posedge clk_i);
        {tx_pop_i, rx_push_i} <= 2'h0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic pop_rx(input logic [32:0] e);
        host.cyc(1'h1, 1'h1, 1'h0, 1'h0, 33'h0);
        chk_b("rx drive", fifo_data_bus_oe_o & frame_end_marker_oe_o,
              1'h1);
        host.cyc(1'h1, 1'h1, 1'h0, 1'h1, 33'h0);
        chk_b("rx release", fifo_data_bus_oe_o | frame_end_marker_oe_o,
              1'h0);
        chk("rx word", host.rd_word, e);
    endtask

    initial begin
        {arst_n_i, tx_event_i, rx_event_i, tx_retry_i, tx_pop_i} = '0;
        {rx_side_status_i, rx_push_i, rx_word_eof_i, rx_word_i} = '0;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        foreach (rows[i]) begin
            rop(rows[i]);
            if (!rows[i].wr) begin
                chk("register", {17'h0, q}, {17'h0, rows[i].d});
            end
        end
        rop('{1'h1, 6'h02, 2'h0, 1'h1, 16'h0220});
        {tx_event_i, rx_event_i} <= 2'h3;
        @(posedge clk_i);
        {tx_event_i, rx_event_i} <= 2'h0;
        repeat (6) @(posedge clk_i);
        chk_b("interrupt raised", interrupt_o, 1'h1);
        for (int i = 0; i < 2; i++) begin
            rop('{1'h0, 6'(i), 2'h0, 1'h1, 16'h0});
            chk("status", {17'h0, q}, 33'h1);
            chk_b("interrupt", interrupt_o, 1'(i == 0));
        end
        tx_retry_i <= 1'h1;
        host.cyc(1'h0, 1'h1, 1'h1, 1'h1, 33'h0);
        chk_b("space", tx_space_ready_o & tx_space_ready_oe_o, 1'h1);
        chk_b("retry", tx_retry_flag_o & tx_retry_flag_oe_o, 1'h1);
        host.cyc(1'h0, 1'h0, 1'h1, 1'h1, 33'h011223344);
        host.cyc(1'h0, 1'h1, 1'h1, 1'h1, 33'h0);
        chk_b("space low", tx_space_ready_o, 1'h0);
        chk("tx head", {tx_word_eof_o, tx_word_o}, 33'h011223344);
        host.fifo_pins_o.order <= 1'h1;
        host.cyc(1'h0, 1'h0, 1'h1, 1'h1, 33'h155667788);
        host.cyc(1'h1, 1'h0, 1'h1, 1'h1, 33'h0deadbeef);
        chk_b("retry released", tx_retry_flag_oe_o, 1'h0);
        mac(1'h1, 33'h0);
        chk("big endian", {tx_word_eof_o, tx_word_o}, 33'h188776655);
        mac(1'h1, 33'h0);
        chk_b("tx empty", tx_word_valid_o, 1'h0);
        rx_side_status_i <= 1'h1;
        mac(1'h0, 33'h0cafe0001);
        host.cyc(1'h1, 1'h1, 1'h0, 1'h1, 33'h0);
        chk_b("rx below", rx_data_ready_o, 1'h0);
        mac(1'h0, 33'h0cafe0002);
        host.cyc(1'h1, 1'h1, 1'h0, 1'h1, 33'h0);
        chk_b("rx ready", rx_data_ready_o & rx_data_ready_oe_o, 1'h1);
        chk_b("rx side", rx_side_status_out_o & rx_side_status_out_oe_o,
              1'h1);
        host.cyc(1'h1, 1'h1, 1'h1, 1'h0, 33'h0);
        pop_rx(33'h0cafe0001);
        pop_rx(33'h0cafe0002);
        chk_b("rx drained", rx_data_ready_o, 1'h0);
        mac(1'h0, 33'h1cafe0003);
        host.cyc(1'h1, 1'h1, 1'h0, 1'h1, 33'h0);
        chk_b("rx packet end", rx_data_ready_o, 1'h1);
        pop_rx(33'h1cafe0003);
        host.cyc(1'h0, 1'h0, 1'h1, 1'h1, 33'h0);
        host.cyc(1'h1, 1'h1, 1'h1, 1'h1, 33'h0);
        chk_b("tx queued", tx_word_valid_o, 1'h1);
        arst_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk_b("reset clears", tx_word_valid_o, 1'h0);
        arst_n_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        rop('{1'h0, 6'h02, 2'h0, 1'h1, 16'h0});
        chk("threshold reset", {17'h0, q}, 33'h0);
        chk_b("tx fifo empty", tx_word_valid_o, 1'h0);
        summarize();
    end
endmodule
